// *** include/fru_pkg.sv ***
// fru_pkg: codes, classes and timing constants of the fault report unit.
// assumes a 20 MHz clk; long counts are derived from a 10 ms tick.
`default_nettype none
package fru_pkg;
  localparam int CLK_HZ = 20_000_000;
  // tick base for all long timeouts
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;
  // handshake timeout 5 s, parameter timeout default 7.88 s, both in ticks
  localparam int HS_TIMEOUT_MS = 5000;
  localparam logic [15:0] HS_TIMEOUT_TICKS = 16'(HS_TIMEOUT_MS / TICK_MS);
  localparam int PARAM_TIMEOUT_DEF_MS = 7880;
  localparam logic [15:0] PARAM_TIMEOUT_DEF = 16'(PARAM_TIMEOUT_DEF_MS / TICK_MS);
  // control function that disables all messages
  localparam logic [3:0] CTRL_DISABLE_MSGS = 4'h5;
  // fault codes
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] CODE_NO_CMD = 16'h0007;
  localparam logic [15:0] CODE_CMD_WRITE = 16'h0008;
  localparam logic [15:0] CODE_PARAM_WRITE = 16'h0009;
  localparam logic [15:0] CODE_NO_CMD_PARAM = 16'h000A;
  localparam logic [15:0] CODE_NO_ERR_CODE = 16'h000B;
  localparam logic [15:0] CODE_CTRL_PARAM_TO = 16'h000C;
  localparam logic [15:0] CODE_HOST_PARAM_TO = 16'h000D;
  localparam logic [15:0] CODE_BUS_ERR = 16'h0023;
  localparam logic [15:0] CODE_ADDR_ERR = 16'h0024;
  localparam logic [15:0] CODE_DIV_BOUNDS = 16'h0026;
  localparam logic [15:0] CODE_BAD_EXC = 16'h0027;
  localparam logic [15:0] CODE_UNUSED_INT = 16'h0028;
  localparam logic [15:0] CODE_ILL_OPCODE = 16'h0029;
  // fault class
  typedef enum logic [1:0] {
    FRU_USER  = 2'b00,
    FRU_HW    = 2'b01,
    FRU_FW    = 2'b10,
    FRU_HW_FW = 2'b11
  } fru_class_e;
endpackage : fru_pkg
`default_nettype wire

// *** src/fru_timeout.sv ***
// fru_timeout: tick counter that pulses once when a limit is reached.
// assumes tick is a one-cycle pulse; counting restarts when run drops.
`timescale 1ns/1ps
`default_nettype none
module fru_timeout (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // control
  input  wire logic        run,
  input  wire logic        tick,
  input  wire logic [15:0] limit,
  // result
  output logic             expired
);
  logic [15:0] count;
  logic        done;
  wire         hitLimit = tick && !done && ((count + 16'h0001) >= limit);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count   <= 16'h0000;
      done    <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= run && hitLimit;
      if (!run) begin
        count <= 16'h0000;
        done  <= 1'b0;
      end else if (hitLimit) begin
        done <= 1'b1;
      end else if (tick && !done) begin
        count <= count + 16'h0001;
      end
    end
  end
endmodule : fru_timeout
`default_nettype wire

// *** src/fru_fault_report.sv ***
// fru_fault_report: fault classification and reporting of the controller board.
// assumes all inputs synchronous to clk; event inputs are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module fru_fault_report #(
  parameter int TICK_CYCLES = fru_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // internal error management call
  input  wire logic        intErrValid,
  input  wire logic [15:0] intErrCode,
  // board fault events
  input  wire logic        watchdogExpired,
  input  wire logic        addressFault,
  input  wire logic        divide_bounds_fault,
  input  wire logic        badException,
  input  wire logic        unused_interrupt_fault,
  input  wire logic        illegal_opcode_fault,
  // host message handshake
  input  wire logic        hostHsEnable,
  input  wire logic        msgSendReq,
  input  wire logic        msgFetched,
  input  wire logic        hostRxBusy,
  // host commands
  input  wire logic        paramWait,
  input  wire logic        ctrlFuncValid,
  input  wire logic [3:0]  ctrlFuncCode,
  input  wire logic        set_param_timeout_cmd,
  input  wire logic [15:0] paramTimeoutTicks,
  input  wire logic        faultCollect,
  // fault report
  output logic [15:0]      faultCode,
  output logic [1:0]       faultClass,
  output logic             faultValid,
  output logic             ctrlErrLed,
  output logic             dataCycleRun,
  output logic             busReset,
  output logic             errMsgPost,
  output logic             msgInvalidate,
  output logic             msgDisabled,
  output logic             needBoardReset
);
  ////////////////////////////////////////////////////////////////////////////
  // tick and timeouts
  logic [23:0] tickCount;
  logic        msgPending;
  logic [15:0] paramLimit;
  wire         tick = (tickCount == 24'(TICK_CYCLES - 1));
  wire         hsExpired;
  wire         paramExpired;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) tickCount <= 24'h00_0000;
    else       tickCount <= tick ? 24'h00_0000 : tickCount + 24'h00_0001;
  end

  // one counter design serves both timeouts
  fru_timeout uHsTimeout (
    .clk     (clk),
    .nrst    (nrst),
    .run     (!hostHsEnable),
    .tick    (tick),
    .limit   (fru_pkg::HS_TIMEOUT_TICKS),
    .expired (hsExpired)
  );

  fru_timeout uParamTimeout (
    .clk     (clk),
    .nrst    (nrst),
    .run     (paramWait),
    .tick    (tick),
    .limit   (paramLimit),
    .expired (paramExpired)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)                      paramLimit <= fru_pkg::PARAM_TIMEOUT_DEF;
    else if (set_param_timeout_cmd) paramLimit <= paramTimeoutTicks;
  end

  ////////////////////////////////////////////////////////////////////////////
  // message bookkeeping
  wire overrun = msgSendReq && msgPending && !msgFetched;

  // a new send wins over a fetch in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) msgPending <= 1'b0;
    else       msgPending <= msgSendReq | (msgPending & ~msgFetched);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)                                       msgDisabled <= 1'b0;
    else if (ctrlFuncValid &&
             ctrlFuncCode == fru_pkg::CTRL_DISABLE_MSGS) msgDisabled <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // classification, stopping faults first
  wire knownCode = intErrCode inside {fru_pkg::CODE_NO_CMD, fru_pkg::CODE_CMD_WRITE,
                                      fru_pkg::CODE_PARAM_WRITE,
                                      fru_pkg::CODE_NO_CMD_PARAM,
                                      fru_pkg::CODE_NO_ERR_CODE,
                                      fru_pkg::CODE_CTRL_PARAM_TO,
                                      fru_pkg::CODE_HOST_PARAM_TO};
  wire unknownCall = intErrValid && !knownCode;
  wire trapEvent   = divide_bounds_fault | badException |
                     unused_interrupt_fault | illegal_opcode_fault;
  wire stopEvent   = unknownCall | watchdogExpired | addressFault | trapEvent;
  wire timeoutEvt  = hsExpired | overrun | paramExpired;
  wire anyFault    = stopEvent | timeoutEvt | intErrValid;

  logic [15:0] next_code;
  logic [1:0]  next_class;
  always_comb begin
    next_code  = fru_pkg::CODE_NONE;
    next_class = fru_pkg::FRU_USER;
    if (unknownCall) begin
      next_code  = fru_pkg::CODE_NO_ERR_CODE;
      next_class = fru_pkg::FRU_FW;
    end else if (watchdogExpired) begin
      next_code  = fru_pkg::CODE_BUS_ERR;
      next_class = fru_pkg::FRU_HW;
    end else if (addressFault) begin
      next_code  = fru_pkg::CODE_ADDR_ERR;
      next_class = fru_pkg::FRU_HW;
    end else if (divide_bounds_fault) begin
      next_code  = fru_pkg::CODE_DIV_BOUNDS;
      next_class = fru_pkg::FRU_HW;
    end else if (badException) begin
      next_code  = fru_pkg::CODE_BAD_EXC;
      next_class = fru_pkg::FRU_HW;
    end else if (unused_interrupt_fault) begin
      next_code  = fru_pkg::CODE_UNUSED_INT;
      next_class = fru_pkg::FRU_HW;
    end else if (illegal_opcode_fault) begin
      next_code  = fru_pkg::CODE_ILL_OPCODE;
      next_class = fru_pkg::FRU_HW_FW;
    end else if (paramExpired) begin
      next_code  = fru_pkg::CODE_HOST_PARAM_TO;
    end else if (hsExpired || overrun) begin
      next_code  = fru_pkg::CODE_CTRL_PARAM_TO;
    end else if (intErrValid) begin
      next_code  = intErrCode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // report registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      faultCode  <= fru_pkg::CODE_NONE;
      faultClass <= fru_pkg::FRU_USER;
      faultValid <= 1'b0;
    end else if (anyFault) begin
      // a new fault wins over a collect in the same cycle
      faultCode  <= next_code;
      faultClass <= next_class;
      faultValid <= 1'b1;
    end else if (faultCollect) begin
      faultValid <= 1'b0;
    end
  end

  // a stop holds until board reset; the host must reset after a trap
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dataCycleRun   <= 1'b1;
      needBoardReset <= 1'b0;
      busReset       <= 1'b0;
    end else begin
      busReset <= stopEvent;
      if (stopEvent) dataCycleRun <= 1'b0;
      if (trapEvent) needBoardReset <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)                           ctrlErrLed <= 1'b0;
    else if (anyFault)                   ctrlErrLed <= 1'b1;
    else if (faultCollect && dataCycleRun) ctrlErrLed <= 1'b0;
  end

  // posted regardless of handshake, overwriting a partial read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      errMsgPost    <= 1'b0;
      msgInvalidate <= 1'b0;
    end else begin
      errMsgPost    <= anyFault && !msgDisabled;
      msgInvalidate <= anyFault && !msgDisabled && hostRxBusy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_stop_seen;
    stopEvent;
  endsequence
  sequence s_stopped_reset;
    busReset && !dataCycleRun && ctrlErrLed;
  endsequence

  chk_stop_resets_bus: assert property (s_stop_seen |=> s_stopped_reset)
    else $error("stop fault did not stop the cycle and reset the bus");
  chk_unknown_code: assert property (unknownCall |=>
      faultCode == fru_pkg::CODE_NO_ERR_CODE && faultClass == fru_pkg::FRU_FW)
    else $error("unknown code not reported as firmware fault");
  chk_user_keeps_run: assert property (timeoutEvt && !stopEvent && dataCycleRun |=>
      dataCycleRun && faultClass == fru_pkg::FRU_USER)
    else $error("timeout fault stopped the data cycle");
  chk_overrun_code: assert property (overrun && !stopEvent && !paramExpired |=>
      faultCode == fru_pkg::CODE_CTRL_PARAM_TO)
    else $error("message overrun not reported");
  chk_post_invalid: assert property (anyFault && !msgDisabled && hostRxBusy |=>
      errMsgPost && msgInvalidate)
    else $error("partial message not invalidated");
  chk_msgs_disabled: assert property (msgDisabled |=> !errMsgPost)
    else $error("message posted while disabled");
  chk_param_code: assert property (paramExpired && !stopEvent |=>
      faultCode == fru_pkg::CODE_HOST_PARAM_TO)
    else $error("parameter timeout not reported");
  chk_limit_load: assert property (set_param_timeout_cmd |=>
      paramLimit == $past(paramTimeoutTicks))
    else $error("parameter timeout not loaded");
  chk_opcode_code: assert property (illegal_opcode_fault && !unknownCall && !watchdogExpired
      && !addressFault && !divide_bounds_fault && !badException && !unused_interrupt_fault
      |=> faultCode == fru_pkg::CODE_ILL_OPCODE && faultClass == fru_pkg::FRU_HW_FW)
    else $error("illegal opcode misreported");
  chk_stop_sticks: assert property (!dataCycleRun |=> !dataCycleRun)
    else $error("data cycle restarted without reset");
  chk_fault_held: assert property (faultValid && !faultCollect && !anyFault |=>
      faultValid && $stable(faultCode))
    else $error("fault code lost before collection");
endmodule : fru_fault_report
`default_nettype wire

// *** tb/fru_host_model.sv ***
// fru_host_model: host controller side of the message handshake.
// assumes bench controls change on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module fru_host_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // bench control
  input  wire logic hsOn,
  input  wire logic stall,
  input  wire logic readReq,
  // device side
  input  wire logic msgSendReq,
  input  wire logic msgInvalidate,
  output logic      hostHsEnable,
  output logic      msgFetched,
  output logic      hostRxBusy
);
  logic       pending;
  logic [1:0] age;
  assign hostHsEnable = hsOn;
  ////////////////////////////////////////////////////////////////////////////////
  // slow collection: a stalled host leaves the message pending
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pending <= 1'b0;
      age <= 2'h0;
      msgFetched <= 1'b0;
      hostRxBusy <= 1'b0;
    end else begin
      msgFetched <= 1'b0;
      age <= pending ? age + 2'h1 : 2'h0;
      if (msgSendReq) begin
        pending <= 1'b1;
      end else if (pending && !stall && age == 2'h2) begin
        pending <= 1'b0;
        msgFetched <= 1'b1;
      end
      // overwritten partial message is dropped, read starts over
      hostRxBusy <= readReq && !msgInvalidate;
    end
  end
endmodule : fru_host_model
`default_nettype wire

// *** tb/fru_fault_report_test.sv ***
// fru_fault_report_test: self-checking bench of the fault report unit.
// assumes the host model is compiled first; 20 MHz clk, 4-cycle tick.
`timescale 1ns/1ps
`default_nettype none
module fru_fault_report_test;
  localparam int TC = 4;
  localparam logic [15:0] TRAP_CODE [6] = '{16'h0023, 16'h0024, 16'h0026,
                                             16'h0027, 16'h0028, 16'h0029};
  localparam logic [1:0]  TRAP_CLASS [6] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h3};
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        intErrValid = 1'b0;
  logic [15:0] intErrCode = 16'h0000;
  logic [5:0]  trap = 6'h00;
  logic        msgSendReq = 1'b0;
  logic        paramWait = 1'b0;
  logic        ctrlFuncValid = 1'b0;
  logic [3:0]  ctrlFuncCode = 4'h0;
  logic        setTo = 1'b0;
  logic [15:0] toTicks = 16'h0000;
  logic        faultCollect = 1'b0;
  logic        hsOn = 1'b1;
  logic        stall = 1'b0;
  logic        readReq = 1'b0;
  logic        hostHsEnable, msgFetched, hostRxBusy;
  logic [15:0] faultCode;
  logic [1:0]  faultClass;
  logic        faultValid, ctrlErrLed, dataCycleRun, busReset;
  logic        errMsgPost, msgInvalidate, msgDisabled, needBoardReset;
  int          mismatches = 0;
  int          checked = 0;
  int          n;
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  fru_fault_report #(.TICK_CYCLES(TC)) fru_fault_report_inst (
    .clk(clk), .nrst(nrst), .intErrValid(intErrValid), .intErrCode(intErrCode),
    .watchdogExpired(trap[0]), .addressFault(trap[1]), .divide_bounds_fault(trap[2]),
    .badException(trap[3]), .unused_interrupt_fault(trap[4]),
    .illegal_opcode_fault(trap[5]), .hostHsEnable(hostHsEnable), .msgSendReq(msgSendReq),
    .msgFetched(msgFetched), .hostRxBusy(hostRxBusy), .paramWait(paramWait),
    .ctrlFuncValid(ctrlFuncValid), .ctrlFuncCode(ctrlFuncCode),
    .set_param_timeout_cmd(setTo), .paramTimeoutTicks(toTicks),
    .faultCollect(faultCollect), .faultCode(faultCode), .faultClass(faultClass),
    .faultValid(faultValid), .ctrlErrLed(ctrlErrLed), .dataCycleRun(dataCycleRun),
    .busReset(busReset), .errMsgPost(errMsgPost), .msgInvalidate(msgInvalidate),
    .msgDisabled(msgDisabled), .needBoardReset(needBoardReset));
  fru_host_model fru_host_model_inst (
    .clk(clk), .nrst(nrst), .hsOn(hsOn), .stall(stall), .readReq(readReq),
    .msgSendReq(msgSendReq), .msgInvalidate(msgInvalidate),
    .hostHsEnable(hostHsEnable), .msgFetched(msgFetched), .hostRxBusy(hostRxBusy));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checked %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  // bounded wait; n counts edges until the fault shows
  task automatic wait_fault(input int maxc);
    n = 0;
    while (faultValid !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > maxc) begin
        mismatches++;
        $display("unexpected wait: no fault within %0d cycles", maxc);
        close_out();
      end
    end
  endtask : wait_fault
  task automatic do_reset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    #1;
  endtask : do_reset
  task automatic collect();
    @(posedge clk);
    faultCollect <= 1'b1;
    @(posedge clk);
    faultCollect <= 1'b0;
    #1;
    chk("valid", faultValid, 0);
  endtask : collect
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_internal();
    logic [15:0] codes [3] = '{16'h000A, 16'h000D, 16'h0030};
    chk("reset code", faultCode, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      intErrValid <= 1'b1;
      intErrCode <= codes[i];
      @(posedge clk);
      intErrValid <= 1'b0;
      #1;
      chk("code", faultCode, i < 2 ? codes[i] : 16'h000B);
      chk("class", faultClass, i < 2 ? 2'h0 : 2'h2);
      chk("led", ctrlErrLed, 1);
      chk("bus reset", busReset, i == 2);
      chk("run", dataCycleRun, i < 2);
      collect();
    end
    do_reset();
    $display("test internal done");
  endtask : t_internal
  task automatic t_traps();
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      trap[i] <= 1'b1;
      @(posedge clk);
      trap[i] <= 1'b0;
      #1;
      chk("trap code", faultCode, TRAP_CODE[i]);
      chk("trap class", faultClass, TRAP_CLASS[i]);
      chk("led", ctrlErrLed, 1);
      chk("bus reset", busReset, 1);
      chk("run", dataCycleRun, 0);
      chk("post", errMsgPost, 1);
      @(posedge clk);
      #1;
      chk("reset pulse", busReset, 0);
      // watchdog and address faults are not processor traps
      chk("board reset", needBoardReset, i >= 2);
      do_reset();
    end
    $display("test traps done");
  endtask : t_traps
  task automatic t_messages();
    @(posedge clk);
    msgSendReq <= 1'b1;
    @(posedge clk);
    msgSendReq <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("prompt fetch", faultValid, 0);
    @(posedge clk);
    stall <= 1'b1;
    msgSendReq <= 1'b1;
    repeat (2) @(posedge clk);
    msgSendReq <= 1'b0;
    wait_fault(3);
    chk("overrun", faultCode, 16'h000C);
    chk("run", dataCycleRun, 1);
    @(posedge clk);
    stall <= 1'b0;
    hsOn <= 1'b0;
    readReq <= 1'b1;
    collect();
    wait_fault(500 * TC + 8);
    chk("hs time", n >= 499 * TC - 4 && n <= 500 * TC, 1);
    chk("hs code", faultCode, 16'h000C);
    chk("class", faultClass, 0);
    chk("run", dataCycleRun, 1);
    chk("post", errMsgPost, 1);
    chk("invalidate", msgInvalidate, 1);
    @(posedge clk);
    hsOn <= 1'b1;
    readReq <= 1'b0;
    collect();
    $display("test messages done");
  endtask : t_messages
  task automatic t_param();
    @(posedge clk);
    paramWait <= 1'b1;
    wait_fault(788 * TC + 8);
    chk("default time", n >= 787 * TC && n <= 788 * TC + 3, 1);
    chk("param code", faultCode, 16'h000D);
    chk("run", dataCycleRun, 1);
    @(posedge clk);
    paramWait <= 1'b0;
    setTo <= 1'b1;
    toTicks <= 16'h000A;
    @(posedge clk);
    setTo <= 1'b0;
    collect();
    @(posedge clk);
    paramWait <= 1'b1;
    wait_fault(10 * TC + 8);
    chk("set time", n >= 9 * TC && n <= 10 * TC + 3, 1);
    @(posedge clk);
    paramWait <= 1'b0;
    collect();
    $display("test param done");
  endtask : t_param
  task automatic t_disable();
    for (int c = 4; c < 6; c++) begin
      @(posedge clk);
      ctrlFuncValid <= 1'b1;
      ctrlFuncCode <= 4'(c);
      @(posedge clk);
      ctrlFuncValid <= 1'b0;
      #1;
      chk("disabled", msgDisabled, c == 5);
    end
    @(posedge clk);
    trap[0] <= 1'b1;
    @(posedge clk);
    trap[0] <= 1'b0;
    #1;
    chk("code", faultCode, 16'h0023);
    chk("no post", errMsgPost, 0);
    do_reset();
    chk("disable cleared", msgDisabled, 0);
    $display("test disable done");
  endtask : t_disable
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    // nrst starts low, so three edges give the three reset cycles
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    #1;
    t_internal();
    t_traps();
    t_messages();
    t_param();
    t_disable();
    close_out();
  end
endmodule : fru_fault_report_test
`default_nettype wire
